// >>> rtl/pfs_flag_byte.sv
// One byte of latched write-one-to-clear status flags
`default_nettype none
module pfs_flag_byte #(
  parameter logic [7:0] LATCH_MASK = 8'hFF
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] set_bits,
  input wire logic [7:0] clear_bits,
  output logic [7:0] flags
);
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      if (LATCH_MASK[i]) begin : g_latch
        logic flag_bit;
        always_ff @(posedge clock or negedge resetn) begin
          if (!resetn) begin
            flag_bit <= pfs_pkg::FLAGS_RESET[i];
          end else if (set_bits[i]) begin
            flag_bit <= 1'b1;
          end else if (clear_bits[i]) begin
            flag_bit <= 1'b0;
          end
        end
        assign flags[i] = flag_bit;
      end else begin : g_zero
        assign flags[i] = 1'b0;
      end
    end
  endgenerate
endmodule
`default_nettype wire

// >>> rtl/pfs_pkg.sv
// Package of offsets, bit positions and types for the fault status bytes
`default_nettype none
package pfs_pkg;
  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_OUTPUT_CURRENT_STATUS = 8'h7B;
  localparam logic [7:0] CMD_INPUT_VOLTAGE_STATUS = 8'h7C;
  localparam logic [7:0] CMD_TEMPERATURE_STATUS = 8'h7D;
  localparam logic [7:0] CMD_LINK_ERROR_FLAG_LOGIC_MEMORY_STATUS = 8'h7E;
  // ----------------------------------------
  // Bit positions
  // ----------------------------------------
  localparam int OUT_OVERCURRENT_FAULT_BIT = 7;
  localparam int OUT_OVERCURRENT_WARN_BIT = 5;
  localparam int IN_OVERVOLT_FAULT_BIT = 7;
  localparam int IN_UNDERVOLT_WARN_BIT = 5;
  localparam int INPUT_TOO_LOW_LIVE_BIT = 3;
  localparam int OVERTEMP_FAULT_BIT = 7;
  localparam int OVERTEMP_WARN_BIT = 6;
  localparam int BAD_COMMAND_FLAG_BIT = 7;
  localparam int BAD_DATA_FLAG_BIT = 6;
  localparam int PEC_FAIL_FLAG_BIT = 5;
  localparam int MEMORY_ERROR_FLAG_BIT = 4;
  localparam int LOGIC_CORE_ERROR_FLAG_BIT = 3;
  localparam int LINK_ERROR_FLAG_BIT = 1;
  // ----------------------------------------
  // Supported latched bits per byte
  // ----------------------------------------
  localparam logic [7:0] OUT_CURRENT_LATCH_MASK = 8'hA0;
  localparam logic [7:0] INPUT_LATCH_MASK = 8'hA0;
  localparam logic [7:0] TEMP_LATCH_MASK = 8'hC0;
  localparam logic [7:0] CML_LATCH_MASK = 8'hFA;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ALERT_MASK_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic LIVE_LOW_RESET = 1'b1;
  localparam int NUM_BYTES = 4;
  // ----------------------------------------
  // Event and bus carriers
  // ----------------------------------------
  typedef struct packed {
    logic out_overcurrent_fault;
    logic out_overcurrent_warn;
    logic in_overvolt_fault;
    logic in_undervolt_warn;
    logic overtemp_fault;
    logic overtemp_warn;
    logic bad_command;
    logic bad_data;
    logic pec_fail;
    logic memory_error;
    logic logic_core_error;
    logic link_error;
    logic back_channel_error;
  } pfs_events_t;
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic clear_faults;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } pfs_req_t;
endpackage
`default_nettype wire

// >>> rtl/pfs_status_bytes.sv
// Fault status byte bank: four status bytes, mask, summary and alert
//
// Behaviour
// - Each status byte uses single-byte read and write, one unsigned byte.
// - Latched flags clear on clear-faults or writing 1; writing 0 keeps them.
// - Output current bit 7 latches overcurrent fault, bit 5 overcurrent warning.
// - Output current bits 6 and 4..0 always read zero.
// - Input bit 7 latches power input overvoltage fault.
// - Input bit 5 latches undervoltage warning, suppressed until input first turns on.
// - Input bit 3 live: high while input below turn-on or bias rail low.
// - Live low-input bit is high after reset and never raises alert.
// - Input bits 6, 4 and 2..0 always read zero.
// - Temperature bit 7 fault, bit 6 warning latch; bits 5..0 read zero.
// - Communication byte bit 7 latches on invalid command code.
// - Communication byte bit 6 latches on invalid data.
// - Communication byte bit 5 latches on packet error check failure.
// - Communication byte bit 4 latches on memory error.
// - Communication byte bit 3 latches on logic core error.
// - Communication byte bit 1 latches on link error; bits 2, 0 zero.
// - A loop follower reports back-channel problems as a communication fault.
// - Summary bit equals OR of all communication byte flags.
// - Every alert-capable bit has its own mask bit.
`default_nettype none
module pfs_status_bytes (
  input wire logic clock,
  input wire logic resetn,
  input wire pfs_pkg::pfs_req_t req,
  input wire pfs_pkg::pfs_events_t events,
  input wire logic input_above_turn_on,
  input wire logic bias_rail_ok,
  input wire logic loop_follower,
  input wire logic [7:0] mask_out_current,
  input wire logic [7:0] mask_input,
  input wire logic [7:0] mask_temp,
  input wire logic [7:0] mask_cml,
  output logic [7:0] rdata,
  output logic rdata_valid,
  output logic cml_summary,
  output logic alert_oe
);
  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic hit_out_current;
  logic hit_input;
  logic hit_temp;
  logic hit_cml;
  logic hit_any;

  always_comb begin
    hit_out_current = 1'b0;
    hit_input = 1'b0;
    hit_temp = 1'b0;
    hit_cml = 1'b0;
    if (req.cmd == pfs_pkg::CMD_OUTPUT_CURRENT_STATUS) begin
      hit_out_current = 1'b1;
    end else if (req.cmd == pfs_pkg::CMD_INPUT_VOLTAGE_STATUS) begin
      hit_input = 1'b1;
    end else if (req.cmd == pfs_pkg::CMD_TEMPERATURE_STATUS) begin
      hit_temp = 1'b1;
    end else if (req.cmd == pfs_pkg::CMD_LINK_ERROR_FLAG_LOGIC_MEMORY_STATUS) begin
      hit_cml = 1'b1;
    end
    hit_any = hit_out_current | hit_input | hit_temp | hit_cml;
  end

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  logic [7:0] clr_out_current;
  logic [7:0] clr_input;
  logic [7:0] clr_temp;
  logic [7:0] clr_cml;
  logic bad_cmd_write;

  always_comb begin
    clr_out_current = 8'h00;
    clr_input = 8'h00;
    clr_temp = 8'h00;
    clr_cml = 8'h00;
    bad_cmd_write = 1'b0;
    if (req.clear_faults) begin
      clr_out_current = 8'hFF;
      clr_input = 8'hFF;
      clr_temp = 8'hFF;
      clr_cml = 8'hFF;
    end else if (req.wr_en) begin
      if (req.cmd == pfs_pkg::CMD_OUTPUT_CURRENT_STATUS) begin
        clr_out_current = req.wdata;
      end else if (req.cmd == pfs_pkg::CMD_INPUT_VOLTAGE_STATUS) begin
        clr_input = req.wdata;
      end else if (req.cmd == pfs_pkg::CMD_TEMPERATURE_STATUS) begin
        clr_temp = req.wdata;
      end else if (req.cmd == pfs_pkg::CMD_LINK_ERROR_FLAG_LOGIC_MEMORY_STATUS) begin
        clr_cml = req.wdata;
      end else begin
        bad_cmd_write = 1'b1;
      end
    end else if (req.rd_en) begin
      if (!hit_any) begin
        bad_cmd_write = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Undervoltage arming
  // ----------------------------------------
  logic uv_armed;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      uv_armed <= 1'b0;
    end else if (input_above_turn_on) begin
      uv_armed <= 1'b1;
    end
  end

  // ----------------------------------------
  // Event set vectors
  // ----------------------------------------
  logic [7:0] set_out_current;
  logic [7:0] set_input;
  logic [7:0] set_temp;
  logic [7:0] set_cml;

  always_comb begin
    set_out_current = 8'h00;
    set_input = 8'h00;
    set_temp = 8'h00;
    set_cml = 8'h00;
    set_out_current[pfs_pkg::OUT_OVERCURRENT_FAULT_BIT] = events.out_overcurrent_fault;
    set_out_current[pfs_pkg::OUT_OVERCURRENT_WARN_BIT] = events.out_overcurrent_warn;
    set_input[pfs_pkg::IN_OVERVOLT_FAULT_BIT] = events.in_overvolt_fault;
    set_input[pfs_pkg::IN_UNDERVOLT_WARN_BIT] = events.in_undervolt_warn & uv_armed;
    set_temp[pfs_pkg::OVERTEMP_FAULT_BIT] = events.overtemp_fault;
    set_temp[pfs_pkg::OVERTEMP_WARN_BIT] = events.overtemp_warn;
    set_cml[pfs_pkg::BAD_COMMAND_FLAG_BIT] = events.bad_command | bad_cmd_write;
    set_cml[pfs_pkg::BAD_DATA_FLAG_BIT] = events.bad_data;
    set_cml[pfs_pkg::PEC_FAIL_FLAG_BIT] = events.pec_fail;
    set_cml[pfs_pkg::MEMORY_ERROR_FLAG_BIT] = events.memory_error;
    set_cml[pfs_pkg::LOGIC_CORE_ERROR_FLAG_BIT] = events.logic_core_error;
    set_cml[pfs_pkg::LINK_ERROR_FLAG_BIT] = events.link_error |
                                            (events.back_channel_error & loop_follower);
  end

  // ----------------------------------------
  // Flag storage
  // ----------------------------------------
  logic [7:0] out_current_status;
  logic [7:0] input_latched;
  logic [7:0] temperature_status;
  logic [7:0] link_error_flag_logic_memory_status;

  pfs_flag_byte #(
    .LATCH_MASK(pfs_pkg::OUT_CURRENT_LATCH_MASK)
  ) u_out_current (
    .clock(clock),
    .resetn(resetn),
    .set_bits(set_out_current),
    .clear_bits(clr_out_current),
    .flags(out_current_status)
  );

  pfs_flag_byte #(
    .LATCH_MASK(pfs_pkg::INPUT_LATCH_MASK)
  ) u_input (
    .clock(clock),
    .resetn(resetn),
    .set_bits(set_input),
    .clear_bits(clr_input),
    .flags(input_latched)
  );

  pfs_flag_byte #(
    .LATCH_MASK(pfs_pkg::TEMP_LATCH_MASK)
  ) u_temp (
    .clock(clock),
    .resetn(resetn),
    .set_bits(set_temp),
    .clear_bits(clr_temp),
    .flags(temperature_status)
  );

  pfs_flag_byte #(
    .LATCH_MASK(pfs_pkg::CML_LATCH_MASK)
  ) u_cml (
    .clock(clock),
    .resetn(resetn),
    .set_bits(set_cml),
    .clear_bits(clr_cml),
    .flags(link_error_flag_logic_memory_status)
  );

  // ----------------------------------------
  // Live low-input bit
  // ----------------------------------------
  logic input_too_low_live;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      input_too_low_live <= pfs_pkg::LIVE_LOW_RESET;
    end else begin
      input_too_low_live <= ~input_above_turn_on | ~bias_rail_ok;
    end
  end

  logic [7:0] input_voltage_status;
  always_comb begin
    input_voltage_status = input_latched;
    input_voltage_status[pfs_pkg::INPUT_TOO_LOW_LIVE_BIT] = input_too_low_live;
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [7:0] read_byte;
  always_comb begin
    read_byte = 8'h00;
    if (hit_out_current) begin
      read_byte = out_current_status;
    end else if (hit_input) begin
      read_byte = input_voltage_status;
    end else if (hit_temp) begin
      read_byte = temperature_status;
    end else if (hit_cml) begin
      read_byte = link_error_flag_logic_memory_status;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata <= pfs_pkg::RDATA_RESET;
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= req.rd_en;
      if (req.rd_en) begin
        rdata <= read_byte;
      end
    end
  end

  // ----------------------------------------
  // Summary and alert
  // ----------------------------------------
  // summary is OR of byte
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cml_summary <= 1'b0;
    end else begin
      cml_summary <= |link_error_flag_logic_memory_status;
    end
  end

  logic [7:0] alert_in_bits;
  always_comb begin
    alert_in_bits = input_latched & pfs_pkg::INPUT_LATCH_MASK;
  end

  // ----------------------------------------
  // Alert
  // ----------------------------------------
  logic [pfs_pkg::NUM_BYTES-1:0] byte_alert;

  always_comb begin
    byte_alert[0] = |(out_current_status & ~mask_out_current);
    byte_alert[1] = |(alert_in_bits & ~mask_input);
    byte_alert[2] = |(temperature_status & ~mask_temp);
    byte_alert[3] = |(link_error_flag_logic_memory_status & ~mask_cml);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      alert_oe <= 1'b0;
    end else begin
      alert_oe <= |byte_alert;
    end
  end
endmodule
`default_nettype wire

// >>> verification/pfs_checker.sv
// Concurrent checks on the fault status byte bank ports
`default_nettype none
module pfs_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire pfs_pkg::pfs_req_t req,
  input wire pfs_pkg::pfs_events_t events,
  input wire logic input_above_turn_on,
  input wire logic bias_rail_ok,
  input wire logic loop_follower,
  input wire logic [7:0] mask_out_current,
  input wire logic [7:0] mask_input,
  input wire logic [7:0] mask_temp,
  input wire logic [7:0] mask_cml,
  input wire logic [7:0] rdata,
  input wire logic rdata_valid,
  input wire logic cml_summary,
  input wire logic alert_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  logic rd_go;
  assign rd_go = req.rd_en;
  sequence quiet_clear;
    req.clear_faults && events == '0 ##1 events == '0 && !req.rd_en && !req.wr_en;
  endsequence
  sequence pec_seen;
    events.pec_fail && !mask_cml[5];
  endsequence
  property zero_bits(logic [7:0] c, logic [7:0] z);
    rdata_valid && $past(req.cmd) == c |-> (rdata & z) == 8'h00;
  endproperty
  rd_answer_a: assert property (rd_go |=> rdata_valid)
    else $error("read not answered");
  rd_only_a: assert property (!rd_go |=> !rdata_valid)
    else $error("valid without read");
  oc_zero_a: assert property (zero_bits(8'h7B, 8'h5F))
    else $error("current byte zero bits set");
  in_zero_a: assert property (zero_bits(8'h7C, 8'h57))
    else $error("input byte zero bits set");
  temp_zero_a: assert property (zero_bits(8'h7D, 8'h3F))
    else $error("temperature byte zero bits set");
  cml_zero_a: assert property (zero_bits(8'h7E, 8'h05))
    else $error("cml byte zero bits set");
  pec_alert_a: assert property (pec_seen |-> ##2 alert_oe)
    else $error("pec failure raised no alert");
  cmd_summary_a: assert property (events.bad_command |-> ##2 cml_summary)
    else $error("summary missed bad command");
  clear_quiet_a: assert property (quiet_clear |=> !cml_summary && !alert_oe)
    else $error("clear left summary or alert");
  mask_all_a: assert property (
    (&mask_out_current && &mask_input && &mask_temp && &mask_cml) [*3] |-> !alert_oe)
    else $error("alert while fully masked");
endmodule
bind pfs_status_bytes pfs_checker u_chk (.clock(clock), .resetn(resetn), .req(req),
  .events(events), .input_above_turn_on(input_above_turn_on), .bias_rail_ok(bias_rail_ok),
  .loop_follower(loop_follower), .mask_out_current(mask_out_current),
  .mask_input(mask_input), .mask_temp(mask_temp), .mask_cml(mask_cml), .rdata(rdata),
  .rdata_valid(rdata_valid), .cml_summary(cml_summary), .alert_oe(alert_oe));
`default_nettype wire

// >>> verification/pfs_host.sv
// Host model issuing single byte status requests
`default_nettype none
module pfs_host (
  input wire logic clock,
  input wire logic [7:0] rdata,
  output var pfs_pkg::pfs_req_t req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  task automatic xfer(input logic w, r, c, input logic [7:0] cmd, wd, output logic [7:0] rd);
    @(posedge clock);
    req <= '{wr_en: w, rd_en: r, clear_faults: c, cmd: cmd, wdata: wd};
    @(posedge clock);
    req <= '{wr_en: 1'b0, rd_en: 1'b0, clear_faults: 1'b0, cmd: ~cmd, wdata: ~wd};
    #1 rd = rdata;
  endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the fault status byte bank
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, resetn = 0, above = 0, bias_ok = 0, follower = 0;
  logic [7:0] m_oc = 0, m_in = 0, m_tp = 0, m_cm = 0, rdata, rd, c;
  logic rdata_valid, cml_summary, alert_oe;
  pfs_pkg::pfs_req_t req;
  pfs_pkg::pfs_events_t ev = '0;
  int fails = 0, checked = 0, cycles = 0;
  localparam logic [7:0] BITS [1:12] = '{8'h02, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80,
    8'h40, 8'h80, 8'h20, 8'h80, 8'h20, 8'h80};
  always #25 clock = ~clock;
  pfs_host u_host (.clock(clock), .rdata(rdata), .req(req));
  pfs_status_bytes DUT (.clock(clock), .resetn(resetn), .req(req), .events(ev),
    .input_above_turn_on(above), .bias_rail_ok(bias_ok), .loop_follower(follower),
    .mask_out_current(m_oc), .mask_input(m_in), .mask_temp(m_tp), .mask_cml(m_cm),
    .rdata(rdata), .rdata_valid(rdata_valid), .cml_summary(cml_summary),
    .alert_oe(alert_oe));
  function automatic logic [7:0] cmd_of(input int i);
    return i > 10 ? 8'h7B : i > 8 ? 8'h7C : i > 6 ? 8'h7D : 8'h7E;
  endfunction
  task automatic pulse(input pfs_pkg::pfs_events_t v);
    @(posedge clock);
    ev <= v;
    @(posedge clock);
    ev <= '0;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, e);
    u_host.xfer(1'b0, 1'b1, 1'b0, a, 8'h00, rd);
    `CHK("rdata", e, rd)
  endtask
  task automatic wr(input logic [7:0] a, d);
    u_host.xfer(1'b1, 1'b0, 1'b0, a, d, rd);
  endtask
  task automatic clr();
    u_host.xfer(1'b0, 1'b0, 1'b1, 8'h00, 8'h00, rd);
  endtask
  task automatic mask_one(input logic [7:0] a, m);
    @(posedge clock);
    m_oc <= (a == 8'h7B) ? m : 8'h00;
    m_in <= (a == 8'h7C) ? m : 8'h00;
    m_tp <= (a == 8'h7D) ? m : 8'h00;
    m_cm <= (a == 8'h7E) ? m : 8'h00;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic finish_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(62349));
    repeat (20) @(posedge clock);
    resetn <= 1;
    rchk(8'h7C, 8'h08);
    `CHK("alert", 1'b0, alert_oe)
    rchk(8'h7B, 8'h00);
    rchk(8'h7D, 8'h00);
    rchk(8'h7E, 8'h00);
    $display("test reset done");
    pulse(13'h0200);
    rchk(8'h7C, 8'h08);
    @(posedge clock);
    above <= 1;
    bias_ok <= 1;
    pulse(13'h0200);
    rchk(8'h7C, 8'h20);
    wr(8'h7C, 8'h5F);
    rchk(8'h7C, 8'h20);
    wr(8'h7C, 8'h20);
    @(posedge clock);
    bias_ok <= 0;
    rchk(8'h7C, 8'h08);
    `CHK("alert", 1'b0, alert_oe)
    @(posedge clock);
    bias_ok <= 1;
    $display("test input done");
    for (int i = 12; i >= 1; i--) begin
      c = cmd_of(i);
      pulse(13'(1) << i);
      `CHK("alert", 1'b1, alert_oe)
      mask_one(c, BITS[i]);
      `CHK("alert", 1'b0, alert_oe)
      mask_one(c, 8'h00);
      wr(c, 8'($urandom) & ~BITS[i]);
      rchk(c, BITS[i]);
      wr(c, BITS[i]);
      rchk(c, 8'h00);
      `CHK("alert", 1'b0, alert_oe)
    end
    $display("test flags done");
    @(posedge clock);
    {m_oc, m_in, m_tp, m_cm} <= '1;
    pulse(13'h0100);
    `CHK("alert", 1'b0, alert_oe)
    rchk(8'h7D, 8'h80);
    fork
      pulse(13'h0100);
      wr(8'h7D, 8'h80);
    join
    rchk(8'h7D, 8'h80);
    clr();
    rchk(8'h7D, 8'h00);
    @(posedge clock);
    {m_oc, m_in, m_tp, m_cm} <= '0;
    pulse(13'h0001);
    `CHK("summary", 1'b0, cml_summary)
    @(posedge clock);
    follower <= 1;
    pulse(13'h0001);
    `CHK("summary", 1'b1, cml_summary)
    clr();
    rchk(8'h7E, 8'h00);
    `CHK("summary", 1'b0, cml_summary)
    rchk(8'h80 | 8'($urandom), 8'h00);
    rchk(8'h7E, 8'h80);
    `CHK("summary", 1'b1, cml_summary)
    $display("test misc done");
    finish_test();
  end
endmodule
`default_nettype wire
